/* core/ggi_pkg.sv */
// ggi_pkg: constants shared by the gauge two-wire device end and host end
// assumes: both ends and the bench compile this package first
package ggi_pkg;
  localparam logic [6:0] GGI_DEV_ADDR = 7'h64;
  localparam logic [6:0] GGI_ARA_ADDR = 7'h0C;
  localparam logic [7:0] GGI_REG_STATUS = 8'h00;
  localparam logic [7:0] GGI_REG_CHARGE_HI = 8'h02;
  localparam logic [7:0] GGI_REG_CHARGE_LO = 8'h03;
  localparam logic [7:0] GGI_REG_VOLT_HI = 8'h08;
  localparam logic [7:0] GGI_REG_VOLT_LO = 8'h09;
  localparam logic [15:0] GGI_CHARGE_RST = 16'h7FFF;
  localparam logic [15:0] GGI_HI_THR_RST = 16'hFFFF;
  localparam logic [15:0] GGI_LO_THR_RST = 16'h0000;
  localparam int GGI_STAT_CHG_HI = 3;
  localparam int GGI_STAT_CHG_LO = 2;
  localparam int GGI_STAT_VOLT_HI = 1;
  localparam int GGI_STAT_VOLT_LO = 0;
  localparam logic [3:0] GGI_BITS_PER_BYTE = 4'h8;
  // host command registers
  localparam logic [3:0] GGI_H_CTRL = 4'h0;
  localparam logic [3:0] GGI_H_WDATA = 4'h1;
  localparam logic [3:0] GGI_H_STATUS = 4'h2;
  localparam logic [3:0] GGI_H_RDATA = 4'h3;
  localparam logic [3:0] GGI_H_IRQ_STAT = 4'h4;
  localparam logic [3:0] GGI_H_IRQ_EN = 4'h5;
  localparam logic [3:0] GGI_H_IRQ_CLR = 4'h6;
  localparam logic [3:0] GGI_H_DIV = 4'h7;
  // ctrl write: [0] start, [1] repeated start, [2] stop, [3] write byte, [4] read byte,
  // [5] ack to send on read (0 ack, 1 refuse)
  localparam int GGI_CMD_START = 0;
  localparam int GGI_CMD_RSTART = 1;
  localparam int GGI_CMD_STOP = 2;
  localparam int GGI_CMD_WRITE = 3;
  localparam int GGI_CMD_READ = 4;
  localparam int GGI_CMD_NACK = 5;
  // bus phase length minus one in mclk cycles (scl half period is two phases), default
  localparam logic [7:0] GGI_DIV_RST = 8'h04;
endpackage

/* core/ggi_bus_if.sv */
// ggi_bus_if: open-drain two-wire bus plus alert line between host and device
// assumes: pull-ups are modelled here; a line is low while any party drives it
`timescale 1ns/1ps
`default_nettype none
interface ggi_bus_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic alert_o_dev;
  logic alert_oe_dev;
  logic scl;
  logic sda;
  logic alert_n;
  assign scl = !(scl_oe_host && !scl_o_host);
  assign sda = !((sda_oe_host && !sda_o_host) || (sda_oe_dev && !sda_o_dev));
  assign alert_n = !(alert_oe_dev && !alert_o_dev);
  modport host (
    output scl_o_host, scl_oe_host, sda_o_host, sda_oe_host,
    input scl, sda, alert_n
  );
  modport dev (
    output sda_o_dev, sda_oe_dev, alert_o_dev, alert_oe_dev,
    input scl, sda
  );
endinterface
`default_nettype wire

/* core/ggi_device.sv */
// ggi_device: target end of the gauge two-wire link, reads, writes and alert response
// assumes: scl and sda come from another domain and are synchronised here
//
// Contract
// - read opens with start, address 1100100, write
// - command byte acked and loaded to pointer
// - repeated start, address read, send pointed register
// - master ack advances pointer, next register sent
// - master ends every read with stop
// - master polls alert with address 0001100 read
// - alerting device acks, sends 11001001
// - lost arbitration aborts, retries next response cycle
// - full address sent releases alert until new event
// - threshold cross sets flag, alert mode pulls pin
// - nine clocks per byte, low acks
// - command 00h returns status register
// - voltage at 08h, high byte first
// - charge count at 02h, high byte first
// - write 02h F0h 01h gives F001h
// - host may rebase charge count in software
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ggi_device (
  input wire logic mclk,
  input wire logic rst_b,
  ggi_bus_if.dev bus,
  input wire logic [15:0] voltage_in,
  input wire logic charge_up,
  input wire logic charge_down,
  input wire logic alert_mode,
  input wire logic [15:0] charge_hi_thr,
  input wire logic [15:0] charge_lo_thr,
  input wire logic [7:0] volt_hi_thr,
  input wire logic [7:0] volt_lo_thr,
  output logic [15:0] charge_count,
  output logic [7:0] status_flags,
  output logic alert_active
);
  typedef enum {GGI_D_IDLE, GGI_D_ADDR, GGI_D_ADDR_ACK, GGI_D_RX, GGI_D_RX_ACK,
    GGI_D_TX, GGI_D_TX_ACK, GGI_D_ARA_TX} ggi_dstate_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    ggi_dstate_t st;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rw;
    logic mnack;
    logic ara;
    logic have_cmd;
    logic [7:0] ptr;
    logic [15:0] charge;
    logic [7:0] flags;
    logic alert;
    logic sda_oe;
    logic alert_oe;
  } ggi_dev_t;
  ggi_dev_t r;
  ggi_dev_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;
  logic [7:0] ara_byte;
  logic [3:0] flag_set;
  assign scl_rise = r.scl_s[1] && !r.scl_q;
  assign scl_fall = !r.scl_s[1] && r.scl_q;
  assign start_c = r.scl_s[1] && r.scl_q && r.sda_q && !r.sda_s[1];
  assign stop_c = r.scl_s[1] && r.scl_q && !r.sda_q && r.sda_s[1];
  assign ara_byte = {ggi_pkg::GGI_DEV_ADDR, 1'b1};
  always_comb begin
    case (r.ptr)
      ggi_pkg::GGI_REG_STATUS: rd_byte = r.flags;
      ggi_pkg::GGI_REG_CHARGE_HI: rd_byte = r.charge[15:8];
      ggi_pkg::GGI_REG_CHARGE_LO: rd_byte = r.charge[7:0];
      ggi_pkg::GGI_REG_VOLT_HI: rd_byte = voltage_in[15:8];
      ggi_pkg::GGI_REG_VOLT_LO: rd_byte = voltage_in[7:0];
      default: rd_byte = 8'h00;
    endcase
  end
  always_comb begin
    flag_set = 4'h0;
    flag_set[ggi_pkg::GGI_STAT_CHG_HI] = r.charge > charge_hi_thr;
    flag_set[ggi_pkg::GGI_STAT_CHG_LO] = r.charge < charge_lo_thr;
    flag_set[ggi_pkg::GGI_STAT_VOLT_HI] = voltage_in[15:8] > volt_hi_thr;
    flag_set[ggi_pkg::GGI_STAT_VOLT_LO] = voltage_in[15:8] < volt_lo_thr;
  end
  always_comb begin
    n = r;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.scl_q = r.scl_s[1];
    n.sda_q = r.sda_s[1];
    if (charge_up && !charge_down) begin
      n.charge = r.charge + 16'h0001;
    end else if (charge_down && !charge_up) begin
      n.charge = r.charge - 16'h0001;
    end
    n.flags[3:0] = r.flags[3:0] | flag_set;
    n.alert_oe = r.alert;
    if (start_c) begin
      n.st = GGI_D_ADDR;
      n.bitn = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = GGI_D_IDLE;
      n.sda_oe = 1'b0;
      n.have_cmd = 1'b0;
    end else begin
      case (r.st)
        GGI_D_IDLE: n.sda_oe = 1'b0;
        GGI_D_ADDR: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.sda_q};
            n.bitn = r.bitn + 4'h1;
          end
          if (scl_fall && r.bitn == ggi_pkg::GGI_BITS_PER_BYTE) begin
            n.rw = r.shreg[0];
            n.ara = 1'b0;
            if (r.shreg[7:1] == ggi_pkg::GGI_DEV_ADDR) begin
              n.st = GGI_D_ADDR_ACK;
              n.sda_oe = 1'b1;
              n.have_cmd = r.shreg[0] ? r.have_cmd : 1'b0;
            end else if (r.shreg == {ggi_pkg::GGI_ARA_ADDR, 1'b1} && r.alert) begin
              n.st = GGI_D_ADDR_ACK;
              n.ara = 1'b1;
              n.sda_oe = 1'b1;
            end else begin
              n.st = GGI_D_IDLE;
            end
          end
        end
        GGI_D_ADDR_ACK, GGI_D_RX_ACK, GGI_D_TX_ACK: begin
          if (r.st == GGI_D_TX_ACK && scl_rise) begin
            n.mnack = r.sda_q; // master ack sampled here, 1 means refused
          end
          if (scl_fall) begin
            n.bitn = 4'h0;
            if (r.st == GGI_D_TX_ACK && r.mnack) begin
              n.st = GGI_D_IDLE;
              n.sda_oe = 1'b0;
            end else if (r.ara) begin
              n.st = GGI_D_ARA_TX;
              n.shreg = ara_byte;
              n.sda_oe = !ara_byte[7];
            end else if (r.rw) begin
              n.st = GGI_D_TX;
              n.shreg = rd_byte;
              n.sda_oe = !rd_byte[7];
              n.ptr = r.ptr + 8'h01;
            end else begin
              n.st = GGI_D_RX;
              n.sda_oe = 1'b0;
            end
          end
        end
        GGI_D_RX: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.sda_q};
            n.bitn = r.bitn + 4'h1;
          end
          if (scl_fall && r.bitn == ggi_pkg::GGI_BITS_PER_BYTE) begin
            n.st = GGI_D_RX_ACK;
            n.sda_oe = 1'b1;
            if (!r.have_cmd) begin
              n.ptr = r.shreg;
              n.have_cmd = 1'b1;
            end else begin
              n.ptr = r.ptr + 8'h01;
              if (r.ptr == ggi_pkg::GGI_REG_CHARGE_HI) begin
                n.charge[15:8] = r.shreg;
              end else if (r.ptr == ggi_pkg::GGI_REG_CHARGE_LO) begin
                n.charge[7:0] = r.shreg;
              end
            end
          end
        end
        GGI_D_TX, GGI_D_ARA_TX: begin
          if (scl_rise) begin
            n.bitn = r.bitn + 4'h1;
            if (r.st == GGI_D_ARA_TX && r.shreg[7] && !r.sda_q) begin
              n.st = GGI_D_IDLE;
              n.sda_oe = 1'b0;
            end
          end
          if (scl_fall && n.st != GGI_D_IDLE) begin
            if (r.bitn == ggi_pkg::GGI_BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              if (r.st == GGI_D_ARA_TX) begin
                n.st = GGI_D_IDLE;
                n.alert = 1'b0;
              end else begin
                n.st = GGI_D_TX_ACK;
              end
            end else begin
              n.shreg = {r.shreg[6:0], 1'b0};
              n.sda_oe = !r.shreg[6];
            end
          end
        end
        default: n.st = GGI_D_IDLE;
      endcase
    end
    // a new crossing rearms the alert and wins over a release in the same cycle
    if ((flag_set & ~r.flags[3:0]) != 4'h0) begin
      n.alert = alert_mode;
    end
    if (!alert_mode) begin
      n.alert = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_q: 1'b1, sda_q: 1'b1, st: GGI_D_IDLE,
        bitn: 4'h0, shreg: 8'h00, rw: 1'b0, mnack: 1'b0, ara: 1'b0, have_cmd: 1'b0, ptr: 8'h00,
        charge: ggi_pkg::GGI_CHARGE_RST, flags: 8'h00, alert: 1'b0, sda_oe: 1'b0,
        alert_oe: 1'b0};
    end else begin
      r <= n;
    end
  end
  assign bus.sda_o_dev = 1'b0;
  assign bus.sda_oe_dev = r.sda_oe;
  assign bus.alert_o_dev = 1'b0;
  assign bus.alert_oe_dev = r.alert_oe;
  assign charge_count = r.charge;
  assign status_flags = r.flags;
  assign alert_active = r.alert_oe;
endmodule // ggi_device
`default_nettype wire

/* core/ggi_host.sv */
// ggi_host: bus master end, one bus primitive per software command
// assumes: software waits for busy low before the next command
`timescale 1ns/1ps
`default_nettype none
module ggi_host (
  input wire logic mclk,
  input wire logic rst_b,
  ggi_bus_if.host bus,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq
);
  typedef enum {GGI_H_IDLE, GGI_H_START, GGI_H_STOP, GGI_H_BYTE} ggi_hstate_t;
  typedef struct packed {
    logic [1:0] sda_s;
    logic [2:0] alert_s;
    ggi_hstate_t st;
    logic [1:0] phase;
    logic [7:0] div;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic [7:0] rx;
    logic ack_rx;
    logic scl_lo;
    logic sda_lo;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic irq;
  } ggi_host_t;
  ggi_host_t r;
  ggi_host_t n;
  logic tick;
  logic [2:0] ev;
  logic [7:0] rd_mux;
  assign tick = r.cnt == 8'h00;
  always_comb begin
    case (addr)
      ggi_pkg::GGI_H_STATUS: rd_mux = {5'h00, !r.alert_s[1], r.ack_rx, r.st != GGI_H_IDLE};
      ggi_pkg::GGI_H_RDATA: rd_mux = r.rx;
      ggi_pkg::GGI_H_IRQ_STAT: rd_mux = {5'h00, r.irq_stat};
      ggi_pkg::GGI_H_IRQ_EN: rd_mux = {5'h00, r.irq_en};
      ggi_pkg::GGI_H_DIV: rd_mux = r.div;
      default: rd_mux = 8'h00;
    endcase
  end
  always_comb begin
    n = r;
    ev = 3'h0;
    n.sda_s = {r.sda_s[0], bus.sda};
    n.alert_s = {r.alert_s[1:0], bus.alert_n};
    n.rdata = rd ? rd_mux : 8'h00;
    n.cnt = tick ? r.div : r.cnt - 8'h01;
    if (r.alert_s[2] && !r.alert_s[1]) begin
      ev[2] = 1'b1; // alert line fell
    end
    if (wr && addr == ggi_pkg::GGI_H_DIV) begin
      n.div = wdata;
    end
    if (wr && addr == ggi_pkg::GGI_H_IRQ_EN) begin
      n.irq_en = wdata[2:0];
    end
    if (wr && addr == ggi_pkg::GGI_H_WDATA) begin
      n.shreg = {wdata, 1'b1};
    end
    if (wr && addr == ggi_pkg::GGI_H_CTRL && r.st == GGI_H_IDLE) begin
      n.phase = 2'h0;
      n.bitn = 4'h0;
      if (wdata[ggi_pkg::GGI_CMD_START] || wdata[ggi_pkg::GGI_CMD_RSTART]) begin
        n.st = GGI_H_START;
      end else if (wdata[ggi_pkg::GGI_CMD_STOP]) begin
        n.st = GGI_H_STOP;
      end else if (wdata[ggi_pkg::GGI_CMD_WRITE]) begin
        n.st = GGI_H_BYTE;
      end else if (wdata[ggi_pkg::GGI_CMD_READ]) begin
        n.st = GGI_H_BYTE;
        n.shreg = {8'hFF, wdata[ggi_pkg::GGI_CMD_NACK]};
      end
    end else if (tick) begin
      n.phase = r.phase + 2'h1;
      case (r.st)
        GGI_H_IDLE: n.phase = 2'h0;
        GGI_H_START: begin
          case (r.phase)
            2'h0: begin n.scl_lo = 1'b1; n.sda_lo = 1'b0; end
            2'h1: n.scl_lo = 1'b0;
            2'h2: n.sda_lo = 1'b1;
            default: begin n.scl_lo = 1'b1; n.st = GGI_H_IDLE; ev[0] = 1'b1; end
          endcase
        end
        GGI_H_STOP: begin
          case (r.phase)
            2'h0: begin n.scl_lo = 1'b1; n.sda_lo = 1'b1; end
            2'h1: n.scl_lo = 1'b0;
            2'h2: n.sda_lo = 1'b0;
            default: begin n.st = GGI_H_IDLE; ev[0] = 1'b1; end
          endcase
        end
        GGI_H_BYTE: begin
          case (r.phase)
            2'h0: begin n.scl_lo = 1'b1; n.sda_lo = !r.shreg[8]; end
            2'h1: n.scl_lo = 1'b0;
            2'h2: begin
              if (r.bitn == ggi_pkg::GGI_BITS_PER_BYTE) begin
                n.ack_rx = !r.sda_s[1];
              end else begin
                n.rx = {r.rx[6:0], r.sda_s[1]};
              end
              n.shreg = {r.shreg[7:0], 1'b1};
            end
            default: begin
              n.scl_lo = 1'b1;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == ggi_pkg::GGI_BITS_PER_BYTE) begin
                n.st = GGI_H_IDLE;
                ev[0] = 1'b1;
                ev[1] = !r.ack_rx;
              end
            end
          endcase
        end
        default: n.st = GGI_H_IDLE;
      endcase
    end
    // set wins over clear
    if (wr && addr == ggi_pkg::GGI_H_IRQ_CLR) begin
      n.irq_stat = r.irq_stat & ~wdata[2:0];
    end
    n.irq_stat = n.irq_stat | ev;
    n.irq = (n.irq_stat & r.irq_en) != 3'h0;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{sda_s: 2'h3, alert_s: 3'h7, st: GGI_H_IDLE, phase: 2'h0,
        div: ggi_pkg::GGI_DIV_RST, cnt: 8'h00, bitn: 4'h0, shreg: 9'h1FF, rx: 8'h00,
        ack_rx: 1'b0, scl_lo: 1'b0, sda_lo: 1'b0, irq_stat: 3'h0, irq_en: 3'h0,
        rdata: 8'h00, irq: 1'b0};
    end else begin
      r <= n;
    end
  end
  assign bus.scl_o_host = 1'b0;
  assign bus.scl_oe_host = r.scl_lo;
  assign bus.sda_o_host = 1'b0;
  assign bus.sda_oe_host = r.sda_lo;
  assign rdata = r.rdata;
  assign irq = r.irq;
endmodule // ggi_host
`default_nettype wire

/* tb/ggi_asserts.sv */
// ggi_asserts: wire-level checks of the gauge two-wire link
// assumes: instantiated once beside the bus interface, fed its resolved lines
`timescale 1ns/1ps
`default_nettype none
module ggi_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic alert_oe_dev
);
  logic scl_q, sda_q, rw, mine, ara;
  logic [3:0] cnt;
  logic [2:0] bidx;
  logic [7:0] sh;
  logic rise, start, ack, dat, b0;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign ack = rise && cnt == 4'h8;
  assign dat = rise && cnt > 4'h0 && cnt < 4'h8;
  assign b0 = ack && bidx == 3'h0;
  // bit and byte position since the last start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      bidx <= 3'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      mine <= 1'b0;
      ara <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt <= 4'h0;
        bidx <= 3'h0;
      end else if (rise) begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        bidx <= bidx + ((cnt == 4'h9) ? 3'h1 : 3'h0);
        sh <= {sh[6:0], sda};
        rw <= b0 ? sh[0] : rw;
        mine <= b0 ? (sh[7:1] == ggi_pkg::GGI_DEV_ADDR) : mine;
        ara <= b0 ? (sh[7:1] == ggi_pkg::GGI_ARA_ADDR) : ara;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_addr_own: assert property (b0 && sh[7:1] == ggi_pkg::GGI_DEV_ADDR |-> !sda)
    else $error("own address not acked");
  a_addr_foreign: assert property (b0 && sh[7:1] != ggi_pkg::GGI_DEV_ADDR &&
    sh[7:1] != ggi_pkg::GGI_ARA_ADDR |-> sda)
    else $error("foreign address acked");
  a_ara_ack: assert property (b0 && sh[7:1] == ggi_pkg::GGI_ARA_ADDR && alert_oe_dev |-> !sda)
    else $error("alert response not acked");
  a_ara_quiet: assert property (b0 && sh[7:1] == ggi_pkg::GGI_ARA_ADDR && !alert_oe_dev |-> sda)
    else $error("alert response acked without alert");
  a_write_ack: assert property (ack && bidx != 3'h0 && mine && !rw |-> !sda)
    else $error("written byte not acked");
  a_read_host_free: assert property (dat && bidx != 3'h0 && rw && (mine || ara) |-> !sda_oe_host)
    else $error("host drives data during read");
  a_read_ack_free: assert property (ack && bidx != 3'h0 && rw && mine |-> !sda_oe_dev)
    else $error("device holds data in master ack slot");
  a_ara_release: assert property (ack && bidx == 3'h1 && ara &&
    sh == {ggi_pkg::GGI_DEV_ADDR, 1'b1} |-> ##[1:200] !alert_oe_dev)
    else $error("alert not released after response");
  a_high_stable: assert property (scl && scl_q |-> $stable(sda_oe_dev))
    else $error("device moved data while clock high");
  a_start_quiet: assert property (start |-> !sda_oe_dev)
    else $error("device drives data at start");
  cov_ara: cover property (b0 && sh[7:1] == ggi_pkg::GGI_ARA_ADDR && !sda);
  cov_read: cover property (ack && rw && mine && bidx == 3'h2);
  cov_foreign: cover property (b0 && sda);
endmodule // ggi_asserts
`default_nettype wire

/* tb/gauge_i2c_read_alert_responder_tb.sv */
// gauge_i2c_read_alert_responder_tb: host and device ends joined, driven by host registers
// assumes: package, interface and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
module gauge_i2c_read_alert_responder_tb;
  localparam logic [7:0] cmd_st = 8'h01 << ggi_pkg::GGI_CMD_START;
  localparam logic [7:0] cmd_rs = 8'h01 << ggi_pkg::GGI_CMD_RSTART;
  localparam logic [7:0] cmd_sp = 8'h01 << ggi_pkg::GGI_CMD_STOP;
  localparam logic [7:0] cmd_wr = 8'h01 << ggi_pkg::GGI_CMD_WRITE;
  localparam logic [7:0] cmd_rd = 8'h01 << ggi_pkg::GGI_CMD_READ;
  localparam logic [7:0] cmd_rdn = cmd_rd | (8'h01 << ggi_pkg::GGI_CMD_NACK);
  localparam logic [7:0] dev_w = {ggi_pkg::GGI_DEV_ADDR, 1'b0};
  localparam logic [7:0] dev_r = {ggi_pkg::GGI_DEV_ADDR, 1'b1};
  localparam logic [7:0] ara_r = {ggi_pkg::GGI_ARA_ADDR, 1'b1};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic charge_up = 1'b0;
  logic alert_mode = 1'b0;
  logic [15:0] lo_thr = 16'h0000;
  logic [7:0] rdata, status_flags, r, s, h, l;
  logic [15:0] charge_count;
  logic irq, alert_active, a;
  int fails = 0;
  int cmp_count = 0;
  ggi_bus_if bus ();
  ggi_device u_ggi_device (.mclk(mclk), .rst_b(rst_b), .bus(bus), .voltage_in(16'hF124),
    .charge_up(charge_up), .charge_down(1'b0), .alert_mode(alert_mode),
    .charge_hi_thr(16'hFFFF), .charge_lo_thr(lo_thr), .volt_hi_thr(8'hFF),
    .volt_lo_thr(8'h00), .charge_count(charge_count), .status_flags(status_flags),
    .alert_active(alert_active));
  ggi_host u_ggi_host (.mclk(mclk), .rst_b(rst_b), .bus(bus), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  ggi_asserts u_ggi_asserts (.mclk(mclk), .rst_b(rst_b), .scl(bus.scl), .sda(bus.sda),
    .sda_oe_host(bus.sda_oe_host), .sda_oe_dev(bus.sda_oe_dev),
    .alert_oe_dev(bus.alert_oe_dev));
  always #50 mclk = !mclk;
  task tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge mclk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] ad, output logic [7:0] d);
    @(posedge mclk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one bus primitive, waits for busy low, returns byte and ack seen
  task op(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] q, output logic ak);
    wr_reg(ggi_pkg::GGI_H_WDATA, d);
    wr_reg(ggi_pkg::GGI_H_CTRL, cmd);
    s = 8'h01;
    for (int i = 0; i < 1000 && s[0] !== 1'b0; i++)
      rd_reg(ggi_pkg::GGI_H_STATUS, s);
    if (s[0] !== 1'b0)
      fails++;
    rd_reg(ggi_pkg::GGI_H_RDATA, q);
    ak = s[1];
  endtask
  task wb(input logic [7:0] d, input logic [7:0] exp_ack);
    op(cmd_wr, d, r, a);
    chk8({7'h00, a}, exp_ack);
  endtask
  task rd2(input logic [7:0] ptr, output logic [7:0] hb, output logic [7:0] lb);
    op(cmd_st, 8'h00, r, a);
    wb(dev_w, 8'h01);
    wb(ptr, 8'h01);
    op(cmd_rs, 8'h00, r, a);
    wb(dev_r, 8'h01);
    op(cmd_rd, 8'h00, hb, a);
    op(cmd_rdn, 8'h00, lb, a);
    op(cmd_sp, 8'h00, r, a);
  endtask
  initial begin
    #6000000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    rd2(ggi_pkg::GGI_REG_STATUS, h, l);
    chk8(h, 8'h00);
    rd2(ggi_pkg::GGI_REG_VOLT_HI, h, l);
    chk8(h, 8'hF1);
    chk8(l, 8'h24);
    op(cmd_st, 8'h00, r, a);
    wb(dev_w, 8'h01);
    wb(ggi_pkg::GGI_REG_CHARGE_HI, 8'h01);
    wb(8'hF0, 8'h01);
    wb(8'h01, 8'h01);
    op(cmd_sp, 8'h00, r, a);
    chk8(charge_count[15:8], 8'hF0);
    rd2(ggi_pkg::GGI_REG_CHARGE_HI, h, l);
    chk8(h, 8'hF0);
    chk8(l, 8'h01);
    @(posedge mclk);
    charge_up <= 1'b1;
    @(posedge mclk);
    charge_up <= 1'b0;
    repeat (2) @(posedge mclk);
    chk8(charge_count[7:0], 8'h02);
    op(cmd_st, 8'h00, r, a);
    wb(8'hA0, 8'h00);
    op(cmd_sp, 8'h00, r, a);
    op(cmd_st, 8'h00, r, a);
    wb(ara_r, 8'h00);
    op(cmd_sp, 8'h00, r, a);
    @(posedge mclk);
    alert_mode <= 1'b1;
    lo_thr <= 16'hF100;
    repeat (10) @(posedge mclk);
    chk8({7'h00, bus.alert_n}, 8'h00);
    chk8({7'h00, alert_active}, 8'h01);
    chk8(status_flags, 8'h01 << ggi_pkg::GGI_STAT_CHG_LO);
    lo_thr <= 16'h0000;
    rd_reg(ggi_pkg::GGI_H_IRQ_STAT, r);
    chk8(r & 8'h04, 8'h04);
    chk8({7'h00, irq}, 8'h00);
    wr_reg(ggi_pkg::GGI_H_IRQ_EN, 8'h04);
    repeat (2) @(posedge mclk);
    chk8({7'h00, irq}, 8'h01);
    rd2(ggi_pkg::GGI_REG_STATUS, h, l);
    chk8(h, 8'h01 << ggi_pkg::GGI_STAT_CHG_LO);
    op(cmd_st, 8'h00, r, a);
    wb(ara_r, 8'h01);
    wb(8'h7F, 8'h00);
    op(cmd_sp, 8'h00, r, a);
    chk8({7'h00, bus.alert_n}, 8'h00);
    op(cmd_st, 8'h00, r, a);
    wb(ara_r, 8'h01);
    op(cmd_rdn, 8'h00, h, a);
    chk8(h, 8'hC9);
    op(cmd_sp, 8'h00, r, a);
    chk8({7'h00, bus.alert_n}, 8'h01);
    chk8({7'h00, alert_active}, 8'h00);
    op(cmd_st, 8'h00, r, a);
    wb(ara_r, 8'h00);
    op(cmd_sp, 8'h00, r, a);
    wr_reg(ggi_pkg::GGI_H_IRQ_CLR, 8'h07);
    repeat (2) @(posedge mclk);
    chk8({7'h00, irq}, 8'h00);
    rd_reg(4'h8, r);
    chk8(r, 8'h00);
    tally_and_finish;
  end
endmodule // gauge_i2c_read_alert_responder_tb
`default_nettype wire
